// ---- pkg/ccsr_pkg.sv ----
package ccsr_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned GPR_N  = 16;
    localparam int unsigned IDX_W  = 4;
    localparam int unsigned BE_W   = 4;
    localparam int unsigned STAT_W = 4;

    // Byte addresses of the word registers.
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 7'h00;
    localparam logic [ADDR_W-1:0] OFS_ISTACK    = 7'h04;
    localparam logic [ADDR_W-1:0] OFS_USTACK    = 7'h08;
    localparam logic [ADDR_W-1:0] OFS_VTBASE    = 7'h0C;
    localparam logic [ADDR_W-1:0] OFS_XTBASE    = 7'h10;
    localparam logic [ADDR_W-1:0] OFS_SAVED_PC  = 7'h14;
    localparam logic [ADDR_W-1:0] OFS_SAVED_ST  = 7'h18;
    localparam logic [ADDR_W-1:0] OFS_FASTVEC   = 7'h1C;
    localparam logic [ADDR_W-1:0] OFS_FLOAT_ST  = 7'h20;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 7'h24;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 7'h28;
    localparam int unsigned       GPR_SEL_BIT   = 6;
    localparam int unsigned       GPR_IDX_LSB   = 2;
    localparam logic [IDX_W-1:0]  SP_IDX        = 4'h0;

    // Status word field positions.
    localparam int unsigned ST_C      = 0;
    localparam int unsigned ST_Z      = 1;
    localparam int unsigned ST_S      = 2;
    localparam int unsigned ST_O      = 3;
    localparam int unsigned ST_I      = 16;
    localparam int unsigned ST_U      = 17;
    localparam int unsigned ST_PM     = 20;
    localparam int unsigned ST_IPL_LO = 24;
    localparam int unsigned ST_IPL_HI = 27;
    localparam logic [DATA_W-1:0] ST_WMASK = 32'h0F13000F;
    localparam logic [DATA_W-1:0] ST_RESET = 32'h00000000;

    // Float status word field positions.
    localparam int unsigned FP_OVF    = 2;
    localparam int unsigned FP_OVF_EN = 10;

    // Event status bit positions.
    localparam int unsigned EV_FPOVF  = 0;
    localparam int unsigned EV_IRQ    = 1;
    localparam int unsigned EV_EXC    = 2;
    localparam int unsigned EV_FAST   = 3;

    localparam logic [DATA_W-1:0] ZERO_W = 32'h00000000;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } ccsr_bus_e;

endpackage

// ---- src/ccsr_regs.sv ----
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ccsr_regs (
    input  wire logic                         I_MCLK,
    input  wire logic                         I_RST_B,
    input  wire logic                         I_CE,
    input  wire logic [ccsr_pkg::ADDR_W-1:0]  I_AVS_ADDRESS,
    input  wire logic                         I_AVS_READ,
    input  wire logic                         I_AVS_WRITE,
    input  wire logic [ccsr_pkg::DATA_W-1:0]  I_AVS_WRITEDATA,
    input  wire logic [ccsr_pkg::BE_W-1:0]    I_AVS_BYTEENABLE,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_AVS_READDATA,
    output logic                              O_AVS_WAITREQUEST,
    output logic                              O_IRQ,
    input  wire logic [ccsr_pkg::IDX_W-1:0]   I_GPR_RD_IDX,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_GPR_RD_DATA,
    input  wire logic                         I_GPR_WE,
    input  wire logic [ccsr_pkg::IDX_W-1:0]   I_GPR_WR_IDX,
    input  wire logic [ccsr_pkg::DATA_W-1:0]  I_GPR_WR_DATA,
    input  wire logic                         I_FLAG_WE,
    input  wire logic [ccsr_pkg::STAT_W-1:0]  I_FLAGS,
    input  wire logic                         I_EXC_ACCEPT,
    input  wire logic                         I_FAST_TAKE,
    input  wire logic [ccsr_pkg::DATA_W-1:0]  I_PC,
    input  wire logic                         I_FAST_RETURN,
    input  wire logic                         I_IRQ_REQ,
    input  wire logic [ccsr_pkg::IDX_W-1:0]   I_IRQ_PRIO,
    input  wire logic                         I_FP_OVF,
    output logic                              O_IRQ_ACCEPT,
    output logic                              O_FP_EXC_REQ,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_STATUS_WORD,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_VECTOR_BASE,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_EXC_BASE,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_FAST_VECTOR,
    output logic      [ccsr_pkg::DATA_W-1:0]  O_RESTORE_PC,
    output logic                              O_USER_MODE
);

    logic [ccsr_pkg::DATA_W-1:0] gpr_q [ccsr_pkg::GPR_N];
    logic [ccsr_pkg::DATA_W-1:0] status_q;
    logic [ccsr_pkg::DATA_W-1:0] istack_q;
    logic [ccsr_pkg::DATA_W-1:0] ustack_q;
    logic [ccsr_pkg::DATA_W-1:0] vtbase_q;
    logic [ccsr_pkg::DATA_W-1:0] xtbase_q;
    logic [ccsr_pkg::DATA_W-1:0] saved_pc_q;
    logic [ccsr_pkg::DATA_W-1:0] saved_st_q;
    logic [ccsr_pkg::DATA_W-1:0] fastvec_q;
    logic [ccsr_pkg::DATA_W-1:0] float_st_q;
    logic [ccsr_pkg::STAT_W-1:0] evt_stat_q;
    logic [ccsr_pkg::STAT_W-1:0] evt_mask_q;
    logic [ccsr_pkg::STAT_W-1:0] evt_set;
    logic [ccsr_pkg::DATA_W-1:0] rd_mux;
    logic [ccsr_pkg::DATA_W-1:0] wr_bits;
    logic [ccsr_pkg::DATA_W-1:0] rd_data_q;
    logic [ccsr_pkg::DATA_W-1:0] gpr_rd_q;
    logic [ccsr_pkg::DATA_W-1:0] active_sp;
    logic [ccsr_pkg::IDX_W-1:0]  bus_idx;
    logic [ccsr_pkg::IDX_W-1:0]  ipl;
    logic                        fp_exc_q;
    logic                        bus_req;
    logic                        bus_wr;
    logic                        bus_gpr;
    logic                        sp_user;
    ccsr_pkg::ccsr_bus_e         bus_state_q;

    ////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then the answer.

    // Every request waits one enabled cycle while read data is prepared.
    assign bus_req           = I_AVS_READ | I_AVS_WRITE;
    // A frozen enable holds the answer back, so no write slips past unseen.
    assign O_AVS_WAITREQUEST = bus_req &
                               ~(I_CE & (bus_state_q == ccsr_pkg::BUS_ACK));
    assign bus_wr = I_CE & I_AVS_WRITE & (bus_state_q == ccsr_pkg::BUS_ACK);
    assign bus_gpr = I_AVS_ADDRESS[ccsr_pkg::GPR_SEL_BIT];
    assign bus_idx = I_AVS_ADDRESS[ccsr_pkg::GPR_SEL_BIT-1:
                                   ccsr_pkg::GPR_IDX_LSB];
    assign O_AVS_READDATA = rd_data_q;

    // The acknowledge state lasts one cycle so a held request is taken once.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            bus_state_q <= ccsr_pkg::BUS_IDLE;
        end else if (I_CE) begin
            case (bus_state_q)
                ccsr_pkg::BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_q <= ccsr_pkg::BUS_ACK;
                    end
                end
                ccsr_pkg::BUS_ACK: begin
                    bus_state_q <= ccsr_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state_q <= ccsr_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Byte lanes select which bits a bus write may change.
    always_comb begin
        wr_bits = ccsr_pkg::ZERO_W;
        for (int b = 0; b < ccsr_pkg::BE_W; b++) begin
            wr_bits[b*8 +: 8] = {8{I_AVS_BYTEENABLE[b]}};
        end
    end

    // Read multiplexer; unmapped words read as zero.
    always_comb begin
        rd_mux = ccsr_pkg::ZERO_W;
        if (bus_gpr) begin
            rd_mux = (bus_idx == ccsr_pkg::SP_IDX) ? active_sp
                                                   : gpr_q[bus_idx];
        end else begin
            case (I_AVS_ADDRESS)
                ccsr_pkg::OFS_STATUS:   rd_mux = status_q;
                ccsr_pkg::OFS_ISTACK:   rd_mux = istack_q;
                ccsr_pkg::OFS_USTACK:   rd_mux = ustack_q;
                ccsr_pkg::OFS_VTBASE:   rd_mux = vtbase_q;
                ccsr_pkg::OFS_XTBASE:   rd_mux = xtbase_q;
                ccsr_pkg::OFS_SAVED_PC: rd_mux = saved_pc_q;
                ccsr_pkg::OFS_SAVED_ST: rd_mux = saved_st_q;
                ccsr_pkg::OFS_FASTVEC:  rd_mux = fastvec_q;
                ccsr_pkg::OFS_FLOAT_ST: rd_mux = float_st_q;
                ccsr_pkg::OFS_EVT_STAT: rd_mux[ccsr_pkg::STAT_W-1:0] =
                                            evt_stat_q;
                ccsr_pkg::OFS_EVT_MASK: rd_mux[ccsr_pkg::STAT_W-1:0] =
                                            evt_mask_q;
                default:                rd_mux = ccsr_pkg::ZERO_W;
            endcase
        end
    end

    // Read data is captured in the wait cycle and stands through the answer.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rd_data_q <= ccsr_pkg::ZERO_W;
        end else if (I_CE && I_AVS_READ &&
                     bus_state_q == ccsr_pkg::BUS_IDLE) begin
            rd_data_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // General registers and the two stack pointers.

    assign sp_user   = status_q[ccsr_pkg::ST_U];
    assign active_sp = sp_user ? ustack_q : istack_q;

    // general register file. Index zero lives in the stack pointers
    // so its entry here stays at the reset value and is never read.
    // A core write wins over a bus write to the same cycle.
    for (genvar g = 0; g < ccsr_pkg::GPR_N; g++) begin : g_gpr
        always_ff @(posedge I_MCLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
                gpr_q[g] <= ccsr_pkg::ZERO_W;
            end else if (I_CE && g != ccsr_pkg::SP_IDX) begin
                if (I_GPR_WE && I_GPR_WR_IDX == g) begin
                    gpr_q[g] <= I_GPR_WR_DATA;
                end else if (bus_wr && bus_gpr && bus_idx == g) begin
                    gpr_q[g] <= (gpr_q[g] & ~wr_bits) |
                                (I_AVS_WRITEDATA & wr_bits);
                end
            end
        end
    end
    // core stack pointer writes go to whichever pointer is active.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            istack_q <= ccsr_pkg::ZERO_W;
            ustack_q <= ccsr_pkg::ZERO_W;
        end else if (I_CE) begin
            if (I_GPR_WE && I_GPR_WR_IDX == ccsr_pkg::SP_IDX) begin
                if (sp_user) begin
                    ustack_q <= I_GPR_WR_DATA;
                end else begin
                    istack_q <= I_GPR_WR_DATA;
                end
            end else if (bus_wr && !bus_gpr) begin
                if (I_AVS_ADDRESS == ccsr_pkg::OFS_ISTACK) begin
                    istack_q <= (istack_q & ~wr_bits) |
                                (I_AVS_WRITEDATA & wr_bits);
                end
                if (I_AVS_ADDRESS == ccsr_pkg::OFS_USTACK) begin
                    ustack_q <= (ustack_q & ~wr_bits) |
                                (I_AVS_WRITEDATA & wr_bits);
                end
            end
        end
    end

    // Core read port is registered, one cycle after the index.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            gpr_rd_q <= ccsr_pkg::ZERO_W;
        end else if (I_CE) begin
            gpr_rd_q <= (I_GPR_RD_IDX == ccsr_pkg::SP_IDX) ?
                        active_sp : gpr_q[I_GPR_RD_IDX];
        end
    end
    assign O_GPR_RD_DATA = gpr_rd_q;

    ////////////////////////////////////////////////////////////////////
    // Table bases, fast vector and fast save registers.

    // table bases and the fast vector are plain software words.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            vtbase_q  <= ccsr_pkg::ZERO_W;
            xtbase_q  <= ccsr_pkg::ZERO_W;
            fastvec_q <= ccsr_pkg::ZERO_W;
        end else if (bus_wr && !bus_gpr) begin
            if (I_AVS_ADDRESS == ccsr_pkg::OFS_VTBASE) begin
                vtbase_q <= (vtbase_q & ~wr_bits) |
                            (I_AVS_WRITEDATA & wr_bits);
            end
            if (I_AVS_ADDRESS == ccsr_pkg::OFS_XTBASE) begin
                xtbase_q <= (xtbase_q & ~wr_bits) |
                            (I_AVS_WRITEDATA & wr_bits);
            end
            if (I_AVS_ADDRESS == ccsr_pkg::OFS_FASTVEC) begin
                fastvec_q <= (fastvec_q & ~wr_bits) |
                             (I_AVS_WRITEDATA & wr_bits);
            end
        end
    end

    // one saved context only: a nested fast entry overwrites it.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            saved_pc_q <= ccsr_pkg::ZERO_W;
            saved_st_q <= ccsr_pkg::ZERO_W;
        end else if (I_CE) begin
            if (I_FAST_TAKE) begin
                saved_pc_q <= I_PC;
                saved_st_q <= status_q;
            end else if (bus_wr && !bus_gpr) begin
                if (I_AVS_ADDRESS == ccsr_pkg::OFS_SAVED_PC) begin
                    saved_pc_q <= (saved_pc_q & ~wr_bits) |
                                  (I_AVS_WRITEDATA & wr_bits);
                end
                if (I_AVS_ADDRESS == ccsr_pkg::OFS_SAVED_ST) begin
                    saved_st_q <= (saved_st_q & ~wr_bits) |
                                  (I_AVS_WRITEDATA & wr_bits &
                                   ccsr_pkg::ST_WMASK);
                end
            end
        end
    end

    // branch target of a fast interrupt.
    assign O_FAST_VECTOR = fastvec_q;
    assign O_RESTORE_PC  = saved_pc_q;
    assign O_VECTOR_BASE = vtbase_q;
    assign O_EXC_BASE    = xtbase_q;

    ////////////////////////////////////////////////////////////////////
    // Processor status word.

    // Earlier branches win: exception entry beats return, flags and bus.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            status_q <= ccsr_pkg::ST_RESET;
        end else if (I_CE) begin
            if (I_EXC_ACCEPT || I_FAST_TAKE) begin
                // entry clears enable, stack and mode bits.
                status_q[ccsr_pkg::ST_I]  <= 1'b0;
                status_q[ccsr_pkg::ST_U]  <= 1'b0;
                status_q[ccsr_pkg::ST_PM] <= 1'b0;
            end else if (I_FAST_RETURN) begin
                status_q <= saved_st_q;
            end else if (I_FLAG_WE) begin
                status_q[ccsr_pkg::ST_O:ccsr_pkg::ST_C] <= I_FLAGS;
            end else if (bus_wr && !bus_gpr &&
                         I_AVS_ADDRESS == ccsr_pkg::OFS_STATUS) begin
                status_q <= (status_q & ~(wr_bits & ccsr_pkg::ST_WMASK)) |
                            (I_AVS_WRITEDATA & wr_bits & ccsr_pkg::ST_WMASK);
            end
        end
    end
    assign O_STATUS_WORD = status_q;
    // mode bit high means user mode.
    assign O_USER_MODE   = status_q[ccsr_pkg::ST_PM];

    // accept only when enabled and above the mask.
    assign ipl = status_q[ccsr_pkg::ST_IPL_HI:ccsr_pkg::ST_IPL_LO];
    assign O_IRQ_ACCEPT = I_IRQ_REQ & status_q[ccsr_pkg::ST_I] &
                          (I_IRQ_PRIO > ipl);

    ////////////////////////////////////////////////////////////////////
    // Float status word and its overflow exception.

    // overflow sets the sticky flag; software enables the exception.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            float_st_q <= ccsr_pkg::ZERO_W;
            fp_exc_q   <= 1'b0;
        end else if (I_CE) begin
            if (bus_wr && !bus_gpr &&
                I_AVS_ADDRESS == ccsr_pkg::OFS_FLOAT_ST) begin
                float_st_q <= (float_st_q & ~wr_bits) |
                              (I_AVS_WRITEDATA & wr_bits);
            end
            if (I_FP_OVF) begin
                float_st_q[ccsr_pkg::FP_OVF] <= 1'b1;
            end
            fp_exc_q <= I_FP_OVF & float_st_q[ccsr_pkg::FP_OVF_EN];
        end
    end
    assign O_FP_EXC_REQ = fp_exc_q;

    ////////////////////////////////////////////////////////////////////
    // Event status, mask and interrupt line.

    // a request is logged whatever the enable bit says.
    always_comb begin
        evt_set = '0;
        evt_set[ccsr_pkg::EV_FPOVF] = I_FP_OVF;
        evt_set[ccsr_pkg::EV_IRQ]   = I_IRQ_REQ;
        evt_set[ccsr_pkg::EV_EXC]   = I_EXC_ACCEPT;
        evt_set[ccsr_pkg::EV_FAST]  = I_FAST_TAKE;
    end

    // Write one to clear; a new event in the same cycle is kept.
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            evt_stat_q <= '0;
            evt_mask_q <= '0;
        end else if (I_CE) begin
            if (bus_wr && !bus_gpr &&
                I_AVS_ADDRESS == ccsr_pkg::OFS_EVT_STAT) begin
                evt_stat_q <= (evt_stat_q & ~(I_AVS_WRITEDATA[
                    ccsr_pkg::STAT_W-1:0] & wr_bits[ccsr_pkg::STAT_W-1:0]))
                    | evt_set;
            end else begin
                evt_stat_q <= evt_stat_q | evt_set;
            end
            if (bus_wr && !bus_gpr &&
                I_AVS_ADDRESS == ccsr_pkg::OFS_EVT_MASK) begin
                evt_mask_q <= (evt_mask_q & ~wr_bits[ccsr_pkg::STAT_W-1:0]) |
                              (I_AVS_WRITEDATA[ccsr_pkg::STAT_W-1:0] &
                               wr_bits[ccsr_pkg::STAT_W-1:0]);
            end
        end
    end
    assign O_IRQ = |(evt_stat_q & evt_mask_q);

    ////////////////////////////////////////////////////////////////////
    // Assertions and cover points.

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);

    property p_sp_read;
        (I_CE && I_GPR_RD_IDX == ccsr_pkg::SP_IDX) |=>
            O_GPR_RD_DATA == ($past(status_q[ccsr_pkg::ST_U]) ?
                              $past(ustack_q) : $past(istack_q));
    endproperty
    a_sp_read: assert property (p_sp_read)
        else $error("Stack read used the wrong pointer.");

    property p_gpr_write;
        (I_CE && I_GPR_WE && I_GPR_WR_IDX != ccsr_pkg::SP_IDX) |=>
            gpr_q[$past(I_GPR_WR_IDX)] == $past(I_GPR_WR_DATA);
    endproperty
    a_gpr_write: assert property (p_gpr_write)
        else $error("General register write was lost.");

    property p_exc_clear;
        (I_CE && (I_EXC_ACCEPT || I_FAST_TAKE)) |=>
            !status_q[ccsr_pkg::ST_I] && !status_q[ccsr_pkg::ST_U] &&
            !O_USER_MODE;
    endproperty
    a_exc_clear: assert property (p_exc_clear)
        else $error("Exception entry left a status bit set.");

    property p_fast_save;
        (I_CE && I_FAST_TAKE) |=>
            saved_pc_q == $past(I_PC) && saved_st_q == $past(status_q);
    endproperty
    a_fast_save: assert property (p_fast_save)
        else $error("Fast entry did not save the context.");

    property p_fast_ret;
        (I_CE && I_FAST_RETURN && !I_FAST_TAKE && !I_EXC_ACCEPT) |=>
            status_q == $past(saved_st_q);
    endproperty
    a_fast_ret: assert property (p_fast_ret)
        else $error("Fast return did not restore status.");

    property p_irq_gate;
        O_IRQ_ACCEPT |-> status_q[ccsr_pkg::ST_I] && (I_IRQ_PRIO > ipl);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Interrupt accepted below mask or disabled.");

    property p_irq_logged;
        (I_CE && I_IRQ_REQ) |=> evt_stat_q[ccsr_pkg::EV_IRQ];
    endproperty
    a_irq_logged: assert property (p_irq_logged)
        else $error("Interrupt request not logged.");

    property p_fp_exc;
        (I_CE && I_FP_OVF && float_st_q[ccsr_pkg::FP_OVF_EN]) |=>
            O_FP_EXC_REQ && float_st_q[ccsr_pkg::FP_OVF];
    endproperty
    a_fp_exc: assert property (p_fp_exc)
        else $error("Enabled float overflow raised no exception.");

    property p_bus_wait;
        (I_CE && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST || !I_CE;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("Bus request waited more than one cycle.");

    c_fast_pair: cover property (I_CE && I_FAST_TAKE ##[1:20]
                                 I_CE && I_FAST_RETURN);
    c_irq_acc:   cover property (O_IRQ_ACCEPT);
    c_bus_read:  cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
    c_irq_line:  cover property (O_IRQ);

endmodule
`default_nettype wire

// ---- verification/ccsr_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// Count each compare; a mismatch prints the name, expected and seen values.
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", n, e, a); \
    end end
module ccsr_regs_tb_top;
    typedef struct {logic [6:0] a; logic [31:0] d; logic [31:0] e;} ccsr_row_s;
    logic        clk, rst_b, rd, wr, fwe, exc, ftk, frt, irq, ovf, gwe;
    logic        wt, oirq, acc, fpx, um;
    logic [6:0]  adr;
    logic [3:0]  gidx, prio, flg, gwi;
    logic [31:0] wd, rdat, gdat, pc, st, vb, xb, fv, rpc, q, gwd;
    int          miscompares, n_compared;
    ccsr_row_s   rows [6];

    // Enable and byte lanes are tied high; stack reads use the core port, except the istack check, which reads over the bus.
    ccsr_regs dut_u (.I_MCLK(clk), .I_RST_B(rst_b), .I_CE(1'b1),
        .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wt), .O_IRQ(oirq),
        .I_GPR_RD_IDX(gidx), .O_GPR_RD_DATA(gdat), .I_GPR_WE(gwe),
        .I_GPR_WR_IDX(gwi), .I_GPR_WR_DATA(gwd),
        .I_FLAG_WE(fwe), .I_FLAGS(flg), .I_EXC_ACCEPT(exc),
        .I_FAST_TAKE(ftk), .I_PC(pc), .I_FAST_RETURN(frt),
        .I_IRQ_REQ(irq), .I_IRQ_PRIO(prio), .I_FP_OVF(ovf),
        .O_IRQ_ACCEPT(acc), .O_FP_EXC_REQ(fpx), .O_STATUS_WORD(st),
        .O_VECTOR_BASE(vb), .O_EXC_BASE(xb), .O_FAST_VECTOR(fv),
        .O_RESTORE_PC(rpc), .O_USER_MODE(um));

    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The run ends only here, also when a bus wait runs out.
    task automatic report_and_stop();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hold the request until waitrequest is sampled low, then release.
    task automatic bus(input logic w, input logic [6:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            i++;
        end while (wt !== 1'b0 && i < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i >= 50) begin
            miscompares++;
            report_and_stop();
        end
        @(posedge clk);
    endtask

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        {rd, wr, fwe, exc, ftk, frt, irq, ovf, gwe} = 9'h000;
        {adr, wd, gidx, prio, flg, pc, gwi, gwd} = '0;
        miscompares = 0;
        n_compared = 0;
        rst_b = 1'b0;
        rows = '{'{7'h0C, 32'h12345678, 32'h12345678},
                 '{7'h10, 32'h9ABCDEF0, 32'h9ABCDEF0},
                 '{7'h1C, 32'h00000400, 32'h00000400},
                 '{7'h2C, 32'hFFFFFFFF, 32'h00000000},
                 '{7'h44, 32'hCAFEF00D, 32'hCAFEF00D},
                 '{7'h00, 32'hFFFFFFFF, 32'h0F13000F}};
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // enable starts low, request still recorded.
        irq <= 1'b1;
        prio <= 4'hF;
        @(negedge clk);
        `CHK("status", 32'h00000000, st)
        `CHK("accept", 1'b0, acc)
        @(posedge clk);
        bus(0, 7'h24, 32'h0);
        `CHK("event", 32'h00000002, q)
        irq <= 1'b0;
        bus(1, 7'h24, 32'h0000000F);
        $display("test reset done");
        foreach (rows[k]) begin
            bus(1, rows[k].a, rows[k].d);
            bus(0, rows[k].a, 32'h0);
            `CHK("row", rows[k].e, q)
        end
        @(negedge clk);
        `CHK("vbase", 32'h12345678, vb)
        `CHK("xbase", 32'h9ABCDEF0, xb)
        `CHK("fvec", 32'h00000400, fv)
        `CHK("mode", 1'b1, um)
        $display("test table done");
        @(posedge clk);
        bus(1, 7'h04, 32'hAAAA0000);
        bus(1, 7'h08, 32'hBBBB0000);
        @(negedge clk);
        `CHK("stack", 32'hBBBB0000, gdat)
        @(posedge clk);
        exc <= 1'b1;
        @(posedge clk);
        exc <= 1'b0;
        @(negedge clk);
        `CHK("exc", 32'h0F00000F, st)
        `CHK("mode", 1'b0, um)
        @(negedge clk);
        `CHK("stack", 32'hAAAA0000, gdat)
        $display("test stack done");
        // accept only above the mask; interrupt masked and cleared.
        @(posedge clk);
        bus(1, 7'h00, 32'h05010000);
        irq <= 1'b1;
        prio <= 4'h5;
        @(negedge clk);
        `CHK("accept", 1'b0, acc)
        @(posedge clk);
        prio <= 4'h6;
        @(negedge clk);
        `CHK("accept", 1'b1, acc)
        @(posedge clk);
        bus(1, 7'h28, 32'h00000000);
        `CHK("irq", 1'b0, oirq)
        bus(1, 7'h28, 32'h00000002);
        `CHK("irq", 1'b1, oirq)
        irq <= 1'b0;
        bus(1, 7'h24, 32'h0000000F);
        `CHK("irq", 1'b0, oirq)
        $display("test irq done");
        pc <= 32'h11110000;
        ftk <= 1'b1;
        @(posedge clk);
        ftk <= 1'b0;
        bus(0, 7'h14, 32'h0);
        `CHK("bpc", 32'h11110000, q)
        bus(0, 7'h18, 32'h0);
        `CHK("bst", 32'h05010000, q)
        fwe <= 1'b1;
        flg <= 4'h9;
        @(posedge clk);
        fwe <= 1'b0;
        @(negedge clk);
        `CHK("flags", 32'h05000009, st)
        @(posedge clk);
        pc <= 32'h22220000;
        ftk <= 1'b1;
        @(posedge clk);
        ftk <= 1'b0;
        bus(0, 7'h18, 32'h0);
        `CHK("bst", 32'h05000009, q)
        bus(1, 7'h00, 32'h05000000);
        frt <= 1'b1;
        @(posedge clk);
        frt <= 1'b0;
        @(negedge clk);
        `CHK("rpc", 32'h22220000, rpc)
        `CHK("ret", 32'h05000009, st)
        $display("test fast done");
        // enabled overflow raises an exception request.
        @(posedge clk);
        bus(1, 7'h20, 32'h00000400);
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        @(negedge clk);
        `CHK("fpexc", 1'b1, fpx)
        @(posedge clk);
        bus(0, 7'h20, 32'h0);
        `CHK("float_status_word", 32'h00000404, q)
        $display("test float done");
        // core writes reach a register and the active stack.
        @(posedge clk);
        gwe <= 1'b1;
        gwi <= 4'h3;
        gwd <= 32'h33330000;
        @(posedge clk);
        gwi <= 4'h0;
        gwd <= 32'h44440000;
        @(posedge clk);
        gwe <= 1'b0;
        bus(0, 7'h4C, 32'h0);
        `CHK("gpr3", 32'h33330000, q)
        bus(0, 7'h04, 32'h0);
        `CHK("istack", 32'h44440000, q)
        $display("test core done");
        report_and_stop();
    end
endmodule
`default_nettype wire
